// ---- sebt_pkg.sv ----
`default_nettype none
package sebt_pkg;
	localparam int          CLK_MHZ      = 50;
	localparam int          BYTE_BITS    = 8;
	localparam int          PAGE_DEPTH   = 16;
	localparam int          MEM_DEPTH    = 128;
	localparam int          PROG_TIME_US = 2000;
	localparam int          PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
	localparam int          QTR_NS       = 100;
	localparam int          QTR_CYCLES   = (QTR_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  DEV_CODE     = 4'hA;
	localparam logic [7:0]  LINE_CTL_OFS = 8'h90;
	localparam logic [7:0]  CMD_OFS      = 8'h94;
	localparam logic [7:0]  TXD_OFS      = 8'h98;
	localparam logic [7:0]  STAT_OFS     = 8'h9C;
	localparam logic [7:0]  RXD_OFS      = 8'hA0;
	localparam int          LC_SCL       = 0;
	localparam int          LC_SDA       = 1;
	localparam int          LC_SCL_IN    = 2;
	localparam int          LC_SDA_IN    = 3;
	localparam logic [7:0]  LINE_CTL_RST = 8'h03;
	localparam int          CMD_START    = 0;
	localparam int          CMD_STOP     = 1;
	localparam int          CMD_WRITE    = 2;
	localparam int          CMD_READ     = 3;
	localparam int          CMD_NACK     = 4;
	localparam int          ST_BUSY      = 0;
	localparam int          ST_ACK       = 1;
	localparam int          ST_RXV       = 2;
	localparam int          ST_XFER      = 3;
	typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_ACK, DS_ACKH, DS_TX, DS_TXACK}
		sebt_dev_st_t;
	typedef enum logic [1:0] {HS_IDLE, HS_START, HS_STOP, HS_BIT}
		sebt_host_st_t;
endpackage
`default_nettype wire

// ---- sebt_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sebt_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;
	// Open-drain lines with a pull-up: any enabled low driver wins.
	assign scl = ~(h_scl_oe & ~h_scl_o);
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
	modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
		input scl, sda);
	modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// ---- sebt_buf.sv ----
`timescale 1ns/100ps
`default_nettype none
module sebt_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rp_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i)
		if (push)
			mem_q[wp_q] <= in_data_i;

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
endmodule
`default_nettype wire

// ---- sebt_dev.sv ----
// Behaviour
// - Host starts transfers only on idle bus.
// - SDA change during SCL high is condition.
// - Bus idle when both lines high.
// - SDA falling with SCL high is start.
// - SDA rising with SCL high is stop.
// - One bit per clock, valid while high.
// - Write keeps last sixteen bytes, FIFO overwrite.
// - Every received byte acknowledged on ninth clock, except a control byte with another code or one arriving during programming.
// - No acknowledge during internal programming.
// - Acknowledge holds SDA low through clock high.
// - Host ends read by withholding acknowledge.
// - After missing acknowledge, target releases SDA.
// - Control byte: code, three ignored, direction.
// - Stop after write data starts programming.
`timescale 1ns/100ps
`default_nettype none
module sebt_dev
	import sebt_pkg::*;
#(
	parameter int         PROG_CYC  = sebt_pkg::PROG_CYCLES,
	parameter logic [3:0] CODE      = sebt_pkg::DEV_CODE,
	parameter int         MEM_WORDS = sebt_pkg::MEM_DEPTH
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	sebt_if.dev             bus,
	output logic            busy_o,
	input  wire logic [6:0] peek_addr_i,
	output logic      [7:0] peek_data_o
);
	import sebt_pkg::*;

	localparam int PW = $clog2(PAGE_DEPTH);

	////////////////////////////////////////////////////////////////////////
	logic [1:0]   scl_ff;
	logic [1:0]   sda_ff;
	logic         scl_p;
	logic         sda_p;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;

	// Both lines pass two flops; the detectors compare the second flop with a third, delayed copy.
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
			scl_p  <= 1'b1;
			sda_p  <= 1'b1;
		end
		else
		begin
			scl_ff <= {scl_ff[0], bus.scl};
			sda_ff <= {sda_ff[0], bus.sda};
			scl_p  <= scl_ff[1];
			sda_p  <= sda_ff[1];
		end

	assign scl_rise  = scl_ff[1] & ~scl_p;
	assign scl_fall  = ~scl_ff[1] & scl_p;
	assign start_det = scl_ff[1] & scl_p & sda_p & ~sda_ff[1];
	assign stop_det  = scl_ff[1] & scl_p & ~sda_p & sda_ff[1];

	////////////////////////////////////////////////////////////////////////
	sebt_dev_st_t st_q;
	logic [2:0]   bcnt_q;
	logic [6:0]   sh_q;
	logic [7:0]   tx_q;
	logic [1:0]   idx_q;
	logic         go_tx_q;
	logic         ack_drv_q;
	logic         wr_pend_q;
	logic [6:0]   ptr_q;
	logic [7:0]   rx_byte;
	logic         byte_done;
	logic         page_wr;
	logic         busy_q;
	logic [7:0]   mem_q [MEM_WORDS];

	assign rx_byte   = {sh_q, sda_ff[1]};
	assign byte_done = scl_rise & (st_q == DS_RX) & (bcnt_q == 3'h7);
	assign page_wr   = byte_done & (idx_q == 2'h2);

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			st_q      <= DS_IDLE;
			bcnt_q    <= 3'h0;
			sh_q      <= 7'h00;
			tx_q      <= 8'hFF;
			idx_q     <= 2'h0;
			go_tx_q   <= 1'b0;
			ack_drv_q <= 1'b0;
			wr_pend_q <= 1'b0;
			ptr_q     <= 7'h00;
		end
		else if (start_det)
		begin
			st_q      <= DS_RX;
			bcnt_q    <= 3'h0;
			idx_q     <= 2'h0;
			ack_drv_q <= 1'b0;
		end
		else if (stop_det)
		begin
			st_q      <= DS_IDLE;
			ack_drv_q <= 1'b0;
			wr_pend_q <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				DS_IDLE: ;
				DS_RX:
					if (scl_rise)
					begin
						sh_q   <= rx_byte[6:0];
						bcnt_q <= bcnt_q + 3'h1;
						if (bcnt_q == 3'h7)
						begin
							st_q      <= DS_ACK;
							ack_drv_q <= 1'b1;
							go_tx_q   <= 1'b0;
							if (idx_q != 2'h2)
								idx_q <= idx_q + 2'h1;
							if (idx_q == 2'h0)
							begin
								// Code in the top nibble, direction in bit 0.
								if (busy_q || rx_byte[7:4] != CODE)
									st_q <= DS_IDLE;
								else if (rx_byte[0])
								begin
									go_tx_q <= 1'b1;
									tx_q    <= mem_q[ptr_q];
									ptr_q   <= ptr_q + 7'h1;
								end
							end
							else if (idx_q == 2'h1)
								ptr_q <= rx_byte[6:0];
							else
							begin
								// Pointer low bits wrap so the oldest byte
								// is the one replaced.
								ptr_q[PW-1:0] <= ptr_q[PW-1:0] + 1'b1;
								wr_pend_q     <= 1'b1;
							end
						end
					end
				DS_ACK:
					if (scl_fall)
						st_q <= DS_ACKH;
				DS_ACKH:
					if (scl_fall)
					begin
						ack_drv_q <= 1'b0;
						bcnt_q    <= 3'h0;
						st_q      <= go_tx_q ? DS_TX : DS_RX;
					end
				DS_TX:
					if (scl_fall)
					begin
						tx_q   <= {tx_q[6:0], 1'b1};
						bcnt_q <= bcnt_q + 3'h1;
						if (bcnt_q == 3'h7)
							st_q <= DS_TXACK;
					end
				DS_TXACK:
					if (scl_rise)
					begin
						if (sda_ff[1])
							st_q <= DS_IDLE;
						else
						begin
							tx_q    <= mem_q[ptr_q];
							ptr_q   <= ptr_q + 7'h1;
							go_tx_q <= 1'b1;
							st_q    <= DS_ACKH;
						end
					end
				default:
					st_q <= DS_IDLE;
			endcase
		end

	////////////////////////////////////////////////////////////////////////
	logic [7:0]            page_q [PAGE_DEPTH];
	logic [PAGE_DEPTH-1:0] pval_q;
	logic [6:PW]           base_q;
	logic [31:0]           tmr_q;
	logic [PW-1:0]         cidx;

	assign cidx = tmr_q[PW-1:0];

	always_ff @(posedge clk_i)
		if (page_wr)
			page_q[ptr_q[PW-1:0]] <= rx_byte;

	always_ff @(posedge clk_i)
		if (rst_i)
			pval_q <= '0;
		else if (page_wr)
			pval_q[ptr_q[PW-1:0]] <= 1'b1;
		else if (busy_q && tmr_q == 32'(PROG_CYC - 1))
			pval_q <= '0;

	always_ff @(posedge clk_i)
		if (rst_i)
			base_q <= '0;
		else if (byte_done && idx_q == 2'h1)
			base_q <= rx_byte[6:PW];

	// Page bytes are committed one per cycle at the head of the cycle;
	// the rest is the programming delay.
	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			busy_q <= 1'b0;
			tmr_q  <= 32'h0;
		end
		else if (!busy_q)
		begin
			tmr_q <= 32'h0;
			if (stop_det && wr_pend_q)
				busy_q <= 1'b1;
		end
		else if (tmr_q == 32'(PROG_CYC - 1))
			busy_q <= 1'b0;
		else
			tmr_q <= tmr_q + 32'h1;

	always_ff @(posedge clk_i)
		if (busy_q && tmr_q < 32'(PAGE_DEPTH) && pval_q[cidx])
			mem_q[{base_q, cidx}] <= page_q[cidx];

	always_ff @(posedge clk_i)
		if (rst_i)
			peek_data_o <= 8'h00;
		else
			peek_data_o <= mem_q[peek_addr_i];

	assign busy_o = busy_q;

	////////////////////////////////////////////////////////////////////////
	logic sda_oe_q;

	always_ff @(posedge clk_i)
		if (rst_i)
			sda_oe_q <= 1'b0;
		else
			sda_oe_q <= ((st_q == DS_ACKH) & ack_drv_q)
				| ((st_q == DS_TX) & ~tx_q[7]);

	assign bus.d_sda_o  = 1'b0;
	assign bus.d_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// ---- sebt_host.sv ----
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module sebt_host
	import sebt_pkg::*;
#(
	parameter int QTR = sebt_pkg::QTR_CYCLES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	sebt_if.host             bus,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	import sebt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [1:0] scl_ff;
	logic [1:0] sda_ff;

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			scl_ff <= 2'h3;
			sda_ff <= 2'h3;
		end
		else
		begin
			scl_ff <= {scl_ff[0], bus.scl};
			sda_ff <= {sda_ff[0], bus.sda};
		end

	////////////////////////////////////////////////////////////////////////
	logic       ack_q;
	logic       acc;
	logic       wr;
	logic [7:0] lc_q;
	logic [7:0] txd_q;
	logic [4:0] op_q;
	logic       pend_q;
	logic       got_ack_q;
	logic       xfer_q;
	logic       busy;
	logic [7:0] rx_data;
	logic       rx_valid;
	logic       rx_pop;

	assign acc    = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr     = acc & wb_we_i & wb_sel_i[0];
	assign rx_pop = acc & ~wb_we_i & (wb_adr_i == RXD_OFS);

	always_ff @(posedge clk_i)
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= acc;

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			lc_q  <= LINE_CTL_RST;
			txd_q <= 8'h00;
		end
		else if (wr)
		begin
			if (wb_adr_i == LINE_CTL_OFS)
				lc_q <= {6'h00, wb_dat_i[1:0]};
			if (wb_adr_i == TXD_OFS)
				txd_q <= wb_dat_i[7:0];
		end

	always_ff @(posedge clk_i)
		if (rst_i)
			wb_dat_o <= 32'h0;
		else if (acc && !wb_we_i)
			unique case (wb_adr_i)
				LINE_CTL_OFS: wb_dat_o <= {28'h0, sda_ff[1], scl_ff[1],
					lc_q[1:0]};
				CMD_OFS:      wb_dat_o <= {27'h0, op_q};
				TXD_OFS:      wb_dat_o <= {24'h0, txd_q};
				STAT_OFS:     wb_dat_o <= {28'h0, xfer_q, rx_valid,
					got_ack_q, busy};
				RXD_OFS:      wb_dat_o <= {24'h0, rx_valid ? rx_data : 8'h00};
				default:      wb_dat_o <= 32'h0;
			endcase

	assign wb_ack_o = ack_q;

	////////////////////////////////////////////////////////////////////////
	sebt_host_st_t st_q;
	logic [31:0]   div_q;
	logic          tick;
	logic [1:0]    ph_q;
	logic [3:0]    bit_q;
	logic [8:0]    sh_q;
	logic [8:0]    rsh_q;
	logic          escl_q;
	logic          esda_q;
	logic          in_ready;
	logic          push;
	logic          go;

	assign tick = (div_q == 32'(QTR - 1));
	assign busy = pend_q | (st_q != HS_IDLE);
	// A read waits for buffer room; a fresh start waits for an idle bus.
	assign go = tick & pend_q
		& (~op_q[CMD_READ] | in_ready)
		& (~op_q[CMD_START] | xfer_q | (scl_ff[1] & sda_ff[1]));

	always_ff @(posedge clk_i)
		if (rst_i || tick)
			div_q <= 32'h0;
		else
			div_q <= div_q + 32'h1;

	always_ff @(posedge clk_i)
		if (rst_i)
		begin
			st_q      <= HS_IDLE;
			op_q      <= 5'h00;
			pend_q    <= 1'b0;
			ph_q      <= 2'h0;
			bit_q     <= 4'h0;
			sh_q      <= 9'h1FF;
			rsh_q     <= 9'h000;
			escl_q    <= 1'b1;
			esda_q    <= 1'b1;
			got_ack_q <= 1'b0;
			xfer_q    <= 1'b0;
			push      <= 1'b0;
		end
		else
		begin
			push <= 1'b0;
			if (wr && wb_adr_i == CMD_OFS && !busy)
			begin
				op_q   <= wb_dat_i[4:0];
				pend_q <= |wb_dat_i[3:0];
			end
			unique case (st_q)
				HS_IDLE:
					if (go)
					begin
						pend_q <= 1'b0;
						ph_q   <= 2'h0;
						bit_q  <= 4'h0;
						escl_q <= scl_ff[1];
						esda_q <= sda_ff[1];
						if (op_q[CMD_START])
							st_q <= HS_START;
						else if (op_q[CMD_STOP])
							st_q <= HS_STOP;
						else
						begin
							st_q <= HS_BIT;
							// Read sends ones and the chosen acknowledge.
							sh_q <= op_q[CMD_READ] ? {8'hFF, op_q[CMD_NACK]}
								: {txd_q, 1'b1};
						end
					end
				HS_START:
					if (tick)
					begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: esda_q <= 1'b1;
							2'h1: escl_q <= 1'b1;
							2'h2: esda_q <= 1'b0;
							2'h3:
							begin
								escl_q <= 1'b0;
								xfer_q <= 1'b1;
								st_q   <= HS_IDLE;
							end
						endcase
					end
				HS_STOP:
					if (tick)
					begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: esda_q <= 1'b0;
							2'h1: escl_q <= 1'b1;
							2'h2: esda_q <= 1'b1;
							2'h3:
							begin
								xfer_q <= 1'b0;
								st_q   <= HS_IDLE;
							end
						endcase
					end
				HS_BIT:
					if (tick)
					begin
						ph_q <= ph_q + 2'h1;
						unique case (ph_q)
							2'h0: esda_q <= sh_q[8];
							2'h1: escl_q <= 1'b1;
							2'h2: rsh_q  <= {rsh_q[7:0], sda_ff[1]};
							2'h3:
							begin
								escl_q <= 1'b0;
								sh_q   <= {sh_q[7:0], 1'b1};
								bit_q  <= bit_q + 4'h1;
								if (bit_q == 4'h8)
								begin
									got_ack_q <= ~rsh_q[0];
									push      <= op_q[CMD_READ];
									st_q      <= HS_IDLE;
								end
							end
						endcase
					end
				default:
					st_q <= HS_IDLE;
			endcase
		end

	////////////////////////////////////////////////////////////////////////
	sebt_buf #(
		.WIDTH (8),
		.DEPTH (2)
	) u_rxbuf (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_data_i   (rsh_q[8:1]),
		.in_valid_i  (push),
		.in_ready_o  (in_ready),
		.out_data_o  (rx_data),
		.out_valid_o (rx_valid),
		.out_ready_i (rx_pop)
	);

	// The engine owns the lines while a command runs (not while only pending)
	// or inside a transfer, so SCL stays low between bytes; otherwise software bit-bangs the lines.
	logic eng_own;

	assign eng_own      = (st_q != HS_IDLE) | xfer_q;
	assign bus.h_scl_o  = 1'b0;
	assign bus.h_sda_o  = 1'b0;
	assign bus.h_scl_oe = eng_own ? ~escl_q : ~lc_q[LC_SCL];
	assign bus.h_sda_oe = eng_own ? ~esda_q : ~lc_q[LC_SDA];
endmodule
`default_nettype wire

// ---- sebt_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module sebt_properties (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic h_scl_o,
	input  wire logic h_scl_oe,
	input  wire logic h_sda_o,
	input  wire logic h_sda_oe,
	input  wire logic d_sda_o,
	input  wire logic d_sda_oe,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic busy_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	reset_release_a: assert property (disable iff (1'b0)
		rst_i |=> !h_scl_oe && !h_sda_oe && !d_sda_oe)
		else $error("line driven during reset");
	idle_after_reset_a: assert property ($fell(rst_i) |-> scl && sda)
		else $error("bus not idle after reset");
	open_drain_a: assert property (!h_scl_o && !h_sda_o && !d_sda_o)
		else $error("line data not held low");
	ack_stable_a: assert property (
		scl && $past(scl) |-> $stable(d_sda_oe))
		else $error("target changed SDA while SCL high");
	ack_setup_a: assert property ($rose(d_sda_oe) |-> !scl [*3])
		else $error("target drove SDA too close to SCL rise");
	busy_quiet_a: assert property (busy_o |-> !d_sda_oe)
		else $error("target drove SDA while programming");
	start_shape_a: assert property (
		$fell(sda) && scl |-> ##[1:12] !scl)
		else $error("start not followed by SCL low");
	stop_idle_a: assert property (
		$rose(sda) && scl |=> (scl && sda) [*3])
		else $error("bus not idle after stop");
endmodule
`default_nettype wire

// ---- test_serial_eeprom_bus_target.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_bus_target;
	import sebt_pkg::*;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy_o;
	logic [3:0]  wb_sel_i;
	logic [7:0]  wb_adr_i, peek_data_o, a, b, base;
	logic [7:0]  exp_mem [0:127];
	logic [6:0]  peek_addr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	int          fail_count, num_checks, cycles, seed, k, n;
	sebt_if bus_if ();
	sebt_host i_sebt_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	// A programming time of 400 cycles, far below the default, still lets acknowledge polling be refused first.
	sebt_dev #(.PROG_CYC(400)) i_sebt_dev (.clk_i(clk_i), .rst_i(rst_i),
		.bus(bus_if), .busy_o(busy_o), .peek_addr_i(peek_addr_i),
		.peek_data_o(peek_data_o));
	sebt_properties i_sebt_properties (.clk_i(clk_i), .rst_i(rst_i),
		.h_scl_o(bus_if.h_scl_o), .h_scl_oe(bus_if.h_scl_oe),
		.h_sda_o(bus_if.h_sda_o), .h_sda_oe(bus_if.h_sda_oe),
		.d_sda_o(bus_if.d_sda_o), .d_sda_oe(bus_if.d_sda_oe),
		.scl(bus_if.scl), .sda(bus_if.sda), .busy_o(busy_o));
	////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			fail_count = fail_count + 1;
			end_sim();
		end
	end
	////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Leaves the final status word in rd once the engine is idle.
	task automatic op(input logic [4:0] c);
		wb(1'b1, CMD_OFS, {27'h0, c});
		do wb(1'b0, STAT_OFS, 32'h0); while (rd[ST_BUSY] === 1'b1);
	endtask
	task automatic put(input logic [7:0] v);
		wb(1'b1, TXD_OFS, {24'h0, v});
		op(5'h04);
	endtask
	////////////////////////////////////////
	initial
	begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		peek_addr_i = 7'h00;
		fail_count = 0;
		num_checks = 0;
		cycles = 0;
		seed = $urandom(32'h3ECF);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, LINE_CTL_OFS, 32'h0);
		check("line_ctl", rd, 32'h0F);
		wb(1'b1, 8'hB0, 32'hFF);
		wb(1'b0, 8'hB0, 32'h0);
		check("unmapped", rd, 32'h0);
		// SCL goes low first so that pulling SDA is no start.
		wb(1'b1, LINE_CTL_OFS, 32'h02);
		wb(1'b1, LINE_CTL_OFS, 32'h00);
		check("lines", 32'({bus_if.scl, bus_if.sda}), 32'h0);
		wb(1'b1, LINE_CTL_OFS, 32'h02);
		wb(1'b1, LINE_CTL_OFS, 32'h03);
		b = 8'($urandom) & 8'hF0;
		if (b[7:4] == DEV_CODE)
			b = b ^ 8'h10;
		op(5'h01);
		put(b);
		check("foreign ack", 32'(rd[ST_ACK]), 32'h0);
		op(5'h02);
		check("idle busy", 32'(busy_o), 32'h0);
		a = (8'($urandom) & 8'h70) | 8'($urandom_range(1, 15));
		base = {1'b0, a[6:4], 4'h0};
		op(5'h01);
		put({DEV_CODE, 4'h0});
		check("ctl ack", 32'(rd[ST_ACK]), 32'h1);
		put(a);
		for (k = 0; k < 18; k++)
		begin
			b = 8'($urandom);
			put(b);
			check("data ack", 32'(rd[ST_ACK]), 32'h1);
			exp_mem[{a[6:4], 4'(a[3:0] + k)}] = b;
		end
		op(5'h02);
		repeat (20) if (busy_o !== 1'b1) @(posedge clk_i);
		check("prog busy", 32'(busy_o), 32'h1);
		n = 0;
		do
		begin
			op(5'h01);
			put({DEV_CODE, 4'h0});
			n++;
		end
		while (rd[ST_ACK] !== 1'b1 && n < 20);
		check("refused polls", 32'(n > 1 && n < 20), 32'h1);
		peek_addr_i <= a[6:0];
		repeat (3) @(posedge clk_i);
		check("peek", 32'(peek_data_o), 32'(exp_mem[a]));
		put(base);
		op(5'h01);
		put({DEV_CODE, 4'h1});
		check("read ack", 32'(rd[ST_ACK]), 32'h1);
		for (k = 0; k < 16; k++)
		begin
			op(k == 15 ? 5'h18 : 5'h08);
			wb(1'b0, RXD_OFS, 32'h0);
			check("rxd", rd, 32'(exp_mem[base + 8'(k)]));
		end
		check("sda released", 32'(bus_if.sda), 32'h1);
		op(5'h02);
		check("no prog", 32'(busy_o), 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
